// *** rtl/cbd_pkg.sv ***
// shared constants and types for the configuration bitstream decompressor
package cbd_pkg;
	localparam int DATA_W = 8; // configuration byte width
	localparam int FIFO_DEPTH = 8; // words buffered ahead of the cell writer
	localparam int FPP_HOLD = 4; // config clocks per parallel word when compressed
	localparam int SER_BITS = 8; // serial bits per assembled byte
	localparam int AS_HALF = 2; // system clocks per half period of the serial memory clock
	localparam logic [1:0] SCHEME_FPP = 2'h0; // fast passive parallel scheme
	localparam logic [1:0] SCHEME_PS = 2'h1; // passive serial scheme
	localparam logic [1:0] SCHEME_AS = 2'h2; // active serial scheme
	localparam logic [1:0] SCHEME_BSCAN = 2'h3; // boundary-scan loading
	localparam int HDR_COMP_BIT = 0; // header byte bit that marks a compressed stream
	localparam int TOK_RUN_BIT = 7; // token bit: run of zero bytes
	localparam int RUN_W = 2; // run length field, length is field plus one
	localparam logic [7:0] ZERO_BYTE = 8'h00; // byte emitted inside a run
	// pins that arrive from outside and pass the synchroniser together
	typedef struct packed {
		logic loadActive; // frame of configuration data in progress
		logic serialData; // serial data pin
		logic [DATA_W-1:0] parData; // parallel data pins
	} cbd_pins_t;
	// one byte with its valid flag
	typedef struct packed {
		logic valid;
		logic [DATA_W-1:0] data;
	} cbd_byte_t;
endpackage

// *** rtl/cbd_fifo.sv ***
// flip-flop fifo with valid and ready on both sides
`timescale 1ns/100ps
`default_nettype none
module cbd_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 8
) (
	input wire logic clk,
	input wire logic resetn,
	input wire logic inValid,
	output logic inReady,
	input wire logic [WIDTH-1:0] inData,
	output logic outValid,
	input wire logic outReady,
	output logic [WIDTH-1:0] outData
);
	localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1; // pointer width
	localparam int CW = $clog2(DEPTH + 1); // count width
	localparam logic [CW-1:0] FULL_CNT = CW'(DEPTH); // count when full
	localparam logic [PW-1:0] LAST_PTR = PW'(DEPTH - 1); // last entry index

	logic [WIDTH-1:0] mem_ff [DEPTH]; // storage entries
	logic [PW-1:0] wrPtr_ff; // next entry to write
	logic [PW-1:0] rdPtr_ff; // next entry to read
	logic [CW-1:0] count_ff; // entries held
	wire logic doWrite; // push this cycle
	wire logic doRead; // pop this cycle
	wire logic [PW-1:0] nxt_wrPtr; // write pointer after a push
	wire logic [PW-1:0] nxt_rdPtr; // read pointer after a pop

	assign inReady = (count_ff != FULL_CNT);
	assign outValid = (count_ff != '0);
	assign outData = mem_ff[rdPtr_ff];
	assign doWrite = inValid && inReady;
	assign doRead = outValid && outReady;
	assign nxt_wrPtr = (wrPtr_ff == LAST_PTR) ? '0 : wrPtr_ff + 1'b1;
	assign nxt_rdPtr = (rdPtr_ff == LAST_PTR) ? '0 : rdPtr_ff + 1'b1;

	// storage entries, one per index
	genvar gi;
	generate
		for (gi = 0; gi < DEPTH; gi++)
		begin : gEntry
			always_ff @(posedge clk or negedge resetn)
			begin
				if (!resetn)
					mem_ff[gi] <= '0;
				else if (doWrite && (wrPtr_ff == PW'(gi)))
					mem_ff[gi] <= inData;
			end
		end
	endgenerate

	// pointers and fill count
	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
		begin
			wrPtr_ff <= '0;
			rdPtr_ff <= '0;
			count_ff <= '0;
		end
		else
		begin
			if (doWrite)
				wrPtr_ff <= nxt_wrPtr;
			if (doRead)
				rdPtr_ff <= nxt_rdPtr;
			if (doWrite && !doRead)
				count_ff <= count_ff + 1'b1;
			else if (doRead && !doWrite)
				count_ff <= count_ff - 1'b1;
		end
	end
endmodule
`default_nettype wire

// *** rtl/cbd_top.sv ***
// configuration loader front end: byte assembly, real-time decompression, cell writes
// Overview of operation
// - expand compressed stream on the fly into cells
// - decompress in parallel, serial schemes; never boundary-scan
// - decompression outpaces delivery, never stalls input
// - each serial device takes compressed or plain data
`timescale 1ns/100ps
`default_nettype none
module cbd_top #(
	parameter int DATA_W = cbd_pkg::DATA_W,
	parameter int FIFO_DEPTH = cbd_pkg::FIFO_DEPTH
) (
	input wire logic clk,
	input wire logic resetn,
	input wire logic [1:0] schemeSel, // loading scheme pins
	input wire logic loadActive, // frame in progress
	input wire logic serialData, // serial data pin
	input wire logic [DATA_W-1:0] parData, // parallel data pins
	input wire logic cellReady, // configuration memory accepts a byte
	output logic [DATA_W-1:0] cellData, // byte to configuration memory
	output logic cellWrite, // byte valid toward configuration memory
	output logic asClkOut, // clock to serial configuration memory
	output logic compressedFlag, // current stream is compressed
	output logic overflowErr, // input byte lost, sticky for the frame
	output logic loadBusy // frame being loaded
);
	typedef enum {ST_IDLE, ST_HEADER, ST_STREAM} cbd_state_t; // frame states

	////////////////////////////////////////////////////////////////////////
	// pin synchronisers
	cbd_pkg::cbd_pins_t pinsMeta_ff; // first stage, read by second only
	cbd_pkg::cbd_pins_t pinsSync_ff; // second stage
	logic [1:0] schemeMeta_ff; // first stage of scheme pins
	logic [1:0] schemeSync_ff; // second stage of scheme pins
	wire cbd_pkg::cbd_pins_t pinsRaw; // pins gathered

	assign pinsRaw = '{loadActive: loadActive, serialData: serialData, parData: parData};

	// two flops on every frame, data and scheme pin; cellReady is used unsynchronised
	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
		begin
			pinsMeta_ff <= '0;
			pinsSync_ff <= '0;
			schemeMeta_ff <= '0;
			schemeSync_ff <= '0;
		end
		else
		begin
			pinsMeta_ff <= pinsRaw;
			pinsSync_ff <= pinsMeta_ff;
			schemeMeta_ff <= schemeSel;
			schemeSync_ff <= schemeMeta_ff;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// frame control
	cbd_state_t state_ff; // frame state
	cbd_state_t nxt_state; // next frame state
	logic compressed_ff; // stream carries compressed data
	logic [1:0] scheme_ff; // scheme latched at frame start
	logic loadBusy_ff; // frame being loaded, registered for the port
	wire logic frameOn; // synchronised frame level
	wire logic frameStart; // idle and frame begins
	wire logic isPar; // parallel scheme active
	wire logic isAs; // active serial scheme active
	wire logic gotByte; // assembled byte this cycle
	wire logic [DATA_W-1:0] asmData; // assembled byte

	assign frameOn = pinsSync_ff.loadActive;
	assign frameStart = (state_ff == ST_IDLE) && frameOn;
	assign isPar = (scheme_ff == cbd_pkg::SCHEME_FPP);
	assign isAs = (scheme_ff == cbd_pkg::SCHEME_AS);

	// header byte first, then payload until frame ends
	always_comb
	begin
		nxt_state = state_ff;
		case (state_ff)
			ST_IDLE:
				if (frameOn)
					nxt_state = ST_HEADER;
			ST_HEADER:
				if (!frameOn)
					nxt_state = ST_IDLE;
				else if (gotByte)
					nxt_state = ST_STREAM;
			ST_STREAM:
				if (!frameOn)
					nxt_state = ST_IDLE;
			default:
				nxt_state = ST_IDLE;
		endcase
	end

	// state, scheme and compression choice
	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
		begin
			state_ff <= ST_IDLE;
			loadBusy_ff <= 1'b0;
			scheme_ff <= cbd_pkg::SCHEME_FPP;
			compressed_ff <= 1'b0;
		end
		else
		begin
			state_ff <= nxt_state;
			loadBusy_ff <= (nxt_state != ST_IDLE); // same timing as the state register
			if (frameStart)
			begin
				scheme_ff <= schemeSync_ff;
				compressed_ff <= 1'b0;
			end
			else if ((state_ff == ST_HEADER) && gotByte)
				compressed_ff <= asmData[cbd_pkg::HDR_COMP_BIT] && (scheme_ff != cbd_pkg::SCHEME_BSCAN);
		end
	end

	////////////////////////////////////////////////////////////////////////
	// byte assembly from serial or parallel pins
	logic [DATA_W-1:0] shift_ff; // serial shift register
	logic [$clog2(cbd_pkg::SER_BITS)-1:0] bitCnt_ff; // bits gathered
	logic [$clog2(cbd_pkg::FPP_HOLD)-1:0] holdCnt_ff; // parallel hold phase
	logic [$clog2(cbd_pkg::AS_HALF)-1:0] divCnt_ff; // serial memory clock divider
	logic asClk_ff; // serial memory clock level
	wire logic inFrame; // header or stream state
	wire logic asRise; // serial memory clock rises now
	wire logic serTake; // sample the serial pin
	wire logic parTake; // sample the parallel pins
	wire logic serDone; // last bit of a byte
	wire logic divWrap; // divider terminal count

	localparam logic [$clog2(cbd_pkg::SER_BITS)-1:0] LAST_BIT = ($clog2(cbd_pkg::SER_BITS))'(cbd_pkg::SER_BITS - 1);
	localparam logic [$clog2(cbd_pkg::FPP_HOLD)-1:0] LAST_HOLD = ($clog2(cbd_pkg::FPP_HOLD))'(cbd_pkg::FPP_HOLD - 1);
	localparam logic [$clog2(cbd_pkg::AS_HALF)-1:0] LAST_DIV = ($clog2(cbd_pkg::AS_HALF))'(cbd_pkg::AS_HALF - 1);

	assign inFrame = (state_ff != ST_IDLE) && frameOn;
	assign divWrap = (divCnt_ff == LAST_DIV);
	assign asRise = divWrap && !asClk_ff;
	assign serTake = inFrame && !isPar && (!isAs || asRise);
	assign serDone = serTake && (bitCnt_ff == LAST_BIT);
	// compressed words are held four clocks, take one per hold period
	assign parTake = inFrame && isPar && (!compressed_ff || (holdCnt_ff == '0));
	assign gotByte = serDone || parTake;
	assign asmData = isPar ? pinsSync_ff.parData : {pinsSync_ff.serialData, shift_ff[DATA_W-1:1]};

	// serial bits arrive low bit first
	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
		begin
			shift_ff <= '0;
			bitCnt_ff <= '0;
		end
		else if (!inFrame)
			bitCnt_ff <= '0;
		else if (serTake)
		begin
			shift_ff <= {pinsSync_ff.serialData, shift_ff[DATA_W-1:1]};
			bitCnt_ff <= serDone ? '0 : bitCnt_ff + 1'b1;
		end
	end

	// hold phase restarts after the header word
	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
			holdCnt_ff <= '0;
		else if (!inFrame || (state_ff == ST_HEADER))
			holdCnt_ff <= '0;
		else if (compressed_ff)
			holdCnt_ff <= (holdCnt_ff == LAST_HOLD) ? '0 : holdCnt_ff + 1'b1;
	end

	// divided clock toward serial memory, runs only in active serial frames
	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
		begin
			divCnt_ff <= '0;
			asClk_ff <= 1'b0;
		end
		else if (!(inFrame && isAs))
		begin
			divCnt_ff <= '0;
			asClk_ff <= 1'b0;
		end
		else
		begin
			divCnt_ff <= divWrap ? '0 : divCnt_ff + 1'b1;
			if (divWrap)
				asClk_ff <= !asClk_ff;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// input holding byte and decompressor
	cbd_pkg::cbd_byte_t inByte_ff; // payload byte waiting for expansion
	logic [cbd_pkg::RUN_W-1:0] runLeft_ff; // zero bytes still to emit
	logic litNext_ff; // next byte is a literal
	logic overflow_ff; // byte lost while holding busy
	wire logic payload; // payload byte assembled
	wire logic fifoReady; // fifo takes a byte
	wire logic inRun; // zero run in progress
	wire logic isRunTok; // held byte is a run token
	wire logic emitValid; // byte offered to fifo
	wire logic [DATA_W-1:0] emitData; // byte offered to fifo
	wire logic consume; // held byte used up
	wire logic emitted; // fifo took the byte

	assign payload = gotByte && (state_ff == ST_STREAM);
	assign inRun = (runLeft_ff != '0);
	assign isRunTok = inByte_ff.data[cbd_pkg::TOK_RUN_BIT];
	// plain streams pass through, compressed ones expand runs and literals
	assign emitValid = compressed_ff ? (inRun || (inByte_ff.valid && (litNext_ff || isRunTok))) : inByte_ff.valid;
	assign emitData = (compressed_ff && (inRun || !litNext_ff)) ? cbd_pkg::ZERO_BYTE : inByte_ff.data;
	assign emitted = emitValid && fifoReady;
	assign consume = inByte_ff.valid && !inRun && (emitted || (compressed_ff && !litNext_ff && !isRunTok));

	// held byte, refilled as each payload byte completes
	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
			inByte_ff <= '0;
		else if (payload)
			inByte_ff <= '{valid: 1'b1, data: asmData};
		else if (consume || !inFrame)
			inByte_ff.valid <= 1'b0;
	end

	// run and literal tracking
	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
		begin
			runLeft_ff <= '0;
			litNext_ff <= 1'b0;
		end
		else if (!inFrame)
		begin
			runLeft_ff <= '0;
			litNext_ff <= 1'b0;
		end
		else if (inRun)
		begin
			if (emitted)
				runLeft_ff <= runLeft_ff - 1'b1;
		end
		else if (consume && compressed_ff)
		begin
			if (litNext_ff)
				litNext_ff <= 1'b0;
			else if (isRunTok)
				runLeft_ff <= inByte_ff.data[cbd_pkg::RUN_W-1:0]; // first zero goes out now
			else
				litNext_ff <= 1'b1;
		end
	end

	// input never waits; a byte landing on an unused one is flagged
	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
			overflow_ff <= 1'b0;
		else if (frameStart)
			overflow_ff <= 1'b0;
		else if (payload && inByte_ff.valid && !consume)
			overflow_ff <= 1'b1;
	end

	////////////////////////////////////////////////////////////////////////
	// buffer and registered cell write stage
	wire logic fifoValid; // fifo holds a byte
	wire logic [DATA_W-1:0] fifoData; // oldest fifo byte
	wire logic stageFree; // output stage can load
	logic [DATA_W-1:0] cellData_ff; // byte to cells
	logic cellWrite_ff; // byte valid to cells

	assign stageFree = !cellWrite_ff || cellReady;

	cbd_fifo #(
		.WIDTH(DATA_W),
		.DEPTH(FIFO_DEPTH)
	) uFifo (
		.clk(clk),
		.resetn(resetn),
		.inValid(emitValid),
		.inReady(fifoReady),
		.inData(emitData),
		.outValid(fifoValid),
		.outReady(stageFree),
		.outData(fifoData)
	);

	// output stage loads whenever empty or accepted
	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
		begin
			cellData_ff <= '0;
			cellWrite_ff <= 1'b0;
		end
		else if (stageFree)
		begin
			cellData_ff <= fifoData;
			cellWrite_ff <= fifoValid;
		end
	end

	assign cellData = cellData_ff;
	assign cellWrite = cellWrite_ff;
	assign asClkOut = asClk_ff;
	assign compressedFlag = compressed_ff;
	assign overflowErr = overflow_ff;
	assign loadBusy = loadBusy_ff;
endmodule
`default_nettype wire

// *** verification/cbd_top_chk.sv ***
// assertion checker watching the decompressor top ports
`timescale 1ns/100ps
`default_nettype none
module cbd_top_chk #(
	parameter int DATA_W = 8,
	parameter int FIFO_DEPTH = 8
) (
	input wire logic clk,
	input wire logic resetn,
	input wire logic [1:0] schemeSel,
	input wire logic loadActive,
	input wire logic serialData,
	input wire logic [DATA_W-1:0] parData,
	input wire logic cellReady,
	input wire logic [DATA_W-1:0] cellData,
	input wire logic cellWrite,
	input wire logic asClkOut,
	input wire logic compressedFlag,
	input wire logic overflowErr,
	input wire logic loadBusy
);
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!resetn);
	////////////////////////////////////////////////////////////
	// byte offered to the cells but not taken
	sequence s_stall;
		cellWrite && !cellReady;
	endsequence
	// serial memory clock starts its high phase inside a frame
	sequence s_asHigh;
		$rose(asClkOut) && loadActive;
	endsequence
	// frame pin held high for a while
	sequence s_inFrame;
		loadActive [*6];
	endsequence
	property p_hold;
		s_stall |=> cellWrite && $stable(cellData);
	endproperty
	property p_busyStart;
		$rose(loadActive) && !loadBusy |-> ##[1:4] loadBusy;
	endproperty
	property p_asIdle;
		!loadBusy && !$past(loadBusy) |-> !asClkOut;
	endproperty
	property p_asToggle;
		s_asHigh |=> asClkOut ##1 !asClkOut;
	endproperty
	property p_scanPlain;
		$rose(compressedFlag) |-> schemeSel != cbd_pkg::SCHEME_BSCAN;
	endproperty
	property p_ovfSticky;
		s_inFrame ##0 overflowErr |=> overflowErr;
	endproperty
	property p_flagInFrame;
		$rose(compressedFlag) |-> loadBusy;
	endproperty
	property p_ovfFull;
		$rose(overflowErr) |-> cellWrite;
	endproperty
	////////////////////////////////////////////////////////////
	a_hold: assert property (p_hold) else $error("cell byte changed while stalled");
	a_busyStart: assert property (p_busyStart) else $error("frame start not seen");
	a_asIdle: assert property (p_asIdle) else $error("memory clock runs while idle");
	a_asToggle: assert property (p_asToggle) else $error("memory clock high phase wrong");
	a_scanPlain: assert property (p_scanPlain) else $error("scan load marked compressed");
	a_ovfSticky: assert property (p_ovfSticky) else $error("overflow cleared in frame");
	a_flagInFrame: assert property (p_flagInFrame) else $error("flag rose outside frame");
	a_ovfFull: assert property (p_ovfFull) else $error("overflow with empty buffer");
endmodule
bind cbd_top cbd_top_chk #(.DATA_W(DATA_W), .FIFO_DEPTH(FIFO_DEPTH)) i_chk (
	.clk(clk), .resetn(resetn), .schemeSel(schemeSel), .loadActive(loadActive),
	.serialData(serialData), .parData(parData), .cellReady(cellReady), .cellData(cellData),
	.cellWrite(cellWrite), .asClkOut(asClkOut), .compressedFlag(compressedFlag),
	.overflowErr(overflowErr), .loadBusy(loadBusy)
);
`default_nettype wire

// *** verification/cbd_host_model.sv ***
// behavioural configuration source: parallel host or serial memory
`timescale 1ns/100ps
`default_nettype none
module cbd_host_model (
	input wire logic clk,
	input wire logic asClkOut,
	output logic [1:0] schemeSel,
	output logic loadActive,
	output logic serialData,
	output logic [7:0] parData
);
	// quiet pins at time zero
	initial
	begin
		schemeSel = cbd_pkg::SCHEME_FPP;
		loadActive = 1'b0;
		serialData = 1'b1;
		parData = 8'h5a;
	end
	// one whole frame; header byte first
	task automatic send_frame(input logic [1:0] scheme, input logic [7:0] q [$]);
		int hold;
		schemeSel <= scheme;
		repeat (4) @(posedge clk);
		// frame opens one clock ahead of the first word or bit
		loadActive <= 1'b1;
		@(posedge clk);
		for (int i = 0; i < q.size(); i++)
		begin
			if (scheme == cbd_pkg::SCHEME_FPP)
			begin
				// one setting per stream, compressed words held four clocks
				hold = (q[0][0] && i > 0) ? cbd_pkg::FPP_HOLD : 1;
				parData <= q[i];
				repeat (hold) @(posedge clk);
			end
			else
				for (int b = 0; b < 8; b++)
				begin
					serialData <= q[i][b];
					// memory moves on once a rising clock has taken the bit
					if (scheme == cbd_pkg::SCHEME_AS)
						@(posedge asClkOut);
					else
						@(posedge clk);
				end
		end
		// released lines show the inverse of their last value
		loadActive <= 1'b0;
		serialData <= ~serialData;
		parData <= ~parData;
		@(posedge clk);
	endtask
endmodule
`default_nettype wire

// *** verification/test_config_bitstream_decompressor.sv ***
// self-checking bench for the configuration bitstream decompressor
`timescale 1ns/100ps
`default_nettype none
`define CHK(name, expv, gotv) \
	begin \
		checks_done++; \
		if ((gotv) !== (expv)) \
		begin \
			num_errors++; \
			$display("Error %s expected %h seen %h", name, expv, gotv); \
		end \
	end
module test_config_bitstream_decompressor;
	typedef logic [7:0] cbd_byteq_t [$];
	logic clk, resetn, cellReady, loadActive, serialData, cellWrite;
	logic asClkOut, compressedFlag, overflowErr, loadBusy, readyRandom, stallAll;
	logic [1:0] schemeSel;
	logic [7:0] parData, cellData;
	int num_errors, checks_done, cycleCount;
	cbd_byteq_t got;
	////////////////////////////////////////////////////////////
	cbd_top i_dut (
		.clk(clk), .resetn(resetn), .schemeSel(schemeSel), .loadActive(loadActive),
		.serialData(serialData), .parData(parData), .cellReady(cellReady), .cellData(cellData),
		.cellWrite(cellWrite), .asClkOut(asClkOut), .compressedFlag(compressedFlag),
		.overflowErr(overflowErr), .loadBusy(loadBusy)
	);
	cbd_host_model i_host (
		.clk(clk), .asClkOut(asClkOut), .schemeSel(schemeSel), .loadActive(loadActive),
		.serialData(serialData), .parData(parData)
	);
	////////////////////////////////////////////////////////////
	// 100 ns clock
	initial
	begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end
	// cell side acceptance, random stalls when asked
	always @(posedge clk)
		cellReady <= stallAll ? 1'b0 : (!readyRandom || ($urandom % 4 != 0));
	// collect every accepted byte
	always @(posedge clk)
		if (cellWrite === 1'b1 && cellReady === 1'b1)
			got.push_back(cellData);
	// hang guard
	always @(posedge clk)
	begin
		cycleCount++;
		if (cycleCount == 30000)
		begin
			num_errors++;
			end_sim();
		end
	end
	////////////////////////////////////////////////////////////
	// random stream with corner tokens up front
	function automatic cbd_byteq_t make_stream(input logic compr, input int n);
		cbd_byteq_t s;
		logic [7:0] r;
		s.push_back({7'($urandom), compr});
		if (compr)
			s = {s, 8'h83, 8'h7f, 8'hff};
		else
			s = {s, 8'hff, 8'h00};
		for (int k = 0; k < n; k++)
		begin
			r = 8'($urandom);
			s.push_back(r);
			if (compr && !r[7])
				s.push_back(8'($urandom));
		end
		return s;
	endfunction
	// bytes the cells should receive
	function automatic cbd_byteq_t expand(input logic [1:0] scheme, input cbd_byteq_t s);
		cbd_byteq_t e;
		int i;
		i = 1;
		if (!s[0][cbd_pkg::HDR_COMP_BIT] || scheme == cbd_pkg::SCHEME_BSCAN)
			return s[1:$];
		while (i < s.size())
		begin
			if (s[i][cbd_pkg::TOK_RUN_BIT])
				repeat (s[i][cbd_pkg::RUN_W-1:0] + 1) e.push_back(cbd_pkg::ZERO_BYTE);
			else
				e.push_back(s[i+1]);
			i += s[i][cbd_pkg::TOK_RUN_BIT] ? 1 : 2;
		end
		return e;
	endfunction
	// one frame sent, drained and compared
	task automatic run_frame(input logic [1:0] scheme, input logic compr, input int n);
		cbd_byteq_t s, e;
		s = make_stream(compr, n);
		e = expand(scheme, s);
		got.delete();
		i_host.send_frame(scheme, s);
		`CHK("compressedFlag", compr && scheme != cbd_pkg::SCHEME_BSCAN, compressedFlag)
		for (int k = 0; k < 800 && got.size() < e.size(); k++)
			@(posedge clk);
		repeat (10) @(posedge clk);
		`CHK("byteCount", e.size(), got.size())
		for (int k = 0; k < e.size() && k < got.size(); k++)
			`CHK("cellData", e[k], got[k])
		`CHK("overflowErr", 1'b0, overflowErr)
	endtask
	// verdict and end of run
	task automatic end_sim();
		$display("checks %0d errors %0d", checks_done, num_errors);
		if (num_errors == 0 && checks_done > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	////////////////////////////////////////////////////////////
	// main sequence
	initial
	begin
		num_errors = 0;
		checks_done = 0;
		cycleCount = 0;
		resetn = 1'b0;
		readyRandom = 1'b0;
		stallAll = 1'b0;
		void'($urandom(32'h97c7_ba15));
		repeat (16) @(posedge clk);
		resetn <= 1'b1;
		repeat (4) @(posedge clk);
		// parallel, passive serial and active serial schemes, plain and compressed in turn
		for (int rep = 0; rep < 2; rep++)
			for (int sc = 0; sc < 3; sc++)
				for (int c = 0; c < 2; c++)
				begin
					readyRandom <= (sc != 0);
					run_frame(2'(sc), c[0], 4 + $urandom % 8);
				end
		// scan load never expands
		run_frame(cbd_pkg::SCHEME_BSCAN, 1'b1, 4);
		// cells blocked: buffer fills, input keeps coming
		readyRandom <= 1'b0;
		stallAll <= 1'b1;
		i_host.send_frame(cbd_pkg::SCHEME_FPP, make_stream(1'b0, 24));
		`CHK("overflowErr", 1'b1, overflowErr)
		stallAll <= 1'b0;
		repeat (40) @(posedge clk);
		// next frame starts clean
		run_frame(cbd_pkg::SCHEME_FPP, 1'b0, 6);
		end_sim();
	end
endmodule
`default_nettype wire
